// ==== dv/dwp_master_model.sv ====
// Two-wire bus master model that clocks the slave under test.
// Assumes a pull-up on data; each clock half lasts four reference clocks.
`timescale 1ns/1ps
module dwp_master_model (
  // Clock
  input wire logic i_ref_clk,
  // Bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_rel
);
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // Data moves mid low phase so the slave never sees it near an edge
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    o_sda_rel <= b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl <= 1'b0;
  endtask
  // Works from idle and as a repeated start
  task automatic start();
    tick(2);
    o_sda_rel <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_rel <= 1'b0;
    tick(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    o_sda_rel <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_rel <= 1'b1;
    tick(4);
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                       output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ab, ak);
  endtask
endmodule

// ==== dv/dwp_slave_monitor.sv ====
// Assertion checker for the dual wiper slave, bound to its top ports.
// Assumes one reference clock and the active high reset of the top.
`timescale 1ns/1ps
module dwp_slave_monitor (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Bus
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  // Straps and wipers
  input wire logic [2:0] i_addr_select_pins,
  input wire logic [dwp_pkg::WIPER_W-1:0] o_wiper_zero_position,
  input wire logic [dwp_pkg::WIPER_W-1:0] o_wiper_one_position
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_sda_only_low: assert property (o_sda == 1'b0)
    else $error("data output driven high");
  a_reset_values: assert property ($fell(i_sys_rst) |->
    o_wiper_zero_position == 8'h00 && o_wiper_one_position == 8'h00)
    else $error("wipers not zero after reset");
  a_reset_release: assert property ($fell(i_sys_rst) |-> o_sda_oe_n [*3])
    else $error("data pulled right after reset");
  // The slave may only move its pull-down while the clock is low
  a_drive_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("data changed with clock high");
  a_ack_held_high: assert property ($rose(i_scl) && !o_sda_oe_n |-> !o_sda_oe_n [*3])
    else $error("pull-down dropped during clock high");
  a_start_released: assert property (i_scl && $fell(i_sda) |-> o_sda_oe_n [*8])
    else $error("data pulled after start");
  a_stop_released: assert property (i_scl && $rose(i_sda) |-> o_sda_oe_n [*8])
    else $error("data pulled after stop");
  a_load_on_ack: assert property ($changed(o_wiper_zero_position) ||
    $changed(o_wiper_one_position) |-> !o_sda_oe_n)
    else $error("wiper loaded outside an acknowledge");
endmodule

////////////////////////////////////////////////////////////
bind dwp_slave dwp_slave_monitor u_mon (
  .i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst),
  .i_scl(i_scl),
  .i_sda(i_sda),
  .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n),
  .i_addr_select_pins(i_addr_select_pins),
  .o_wiper_zero_position(o_wiper_zero_position),
  .o_wiper_one_position(o_wiper_one_position)
);

// ==== dv/tb_dual_wiper_i2c_slave.sv ====
// Self-checking bench for the dual wiper slave and its FIFO.
// Assumes dwp_master_model drives the bus; data has a pull-up.
`timescale 1ns/1ps
module tb_dual_wiper_i2c_slave;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] sel = 3'h2;
  logic scl;
  logic rel;
  logic sda_q;
  logic oe_n;
  logic [7:0] wz;
  logic [7:0] wo;
  logic [15:0] rnd = 16'hfc0c;
  logic [7:0] cmds [3] = '{dwp_pkg::CMD_WR_ZERO, dwp_pkg::CMD_WR_ONE, dwp_pkg::CMD_WR_BOTH};
  int n_errors = 0;
  int compares = 0;
  int w0 = 0;
  int w1 = 0;
  wire sda = rel & oe_n;

  always #50 ref_clk = ~ref_clk;
  dwp_master_model m (.i_ref_clk(ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(rel));
  dwp_slave dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_q), .o_sda_oe_n(oe_n), .i_addr_select_pins(sel),
    .o_wiper_zero_position(wz), .o_wiper_one_position(wo));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_w();
    m.tick(4);
    chk("wiper0", w0[7:0], wz);
    chk("wiper1", w1[7:0], wo);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, int n);
    logic [7:0] rx;
    logic ak;
    logic hit;
    m.start();
    // Straps may have moved just before the call; judge them once the start is out
    hit = (a[7:1] === {4'ha, sel});
    m.xbyte(a, 1'b1, rx, ak);
    chk("addr ack", !hit, ak);
    m.xbyte(c, 1'b1, rx, ak);
    chk("cmd ack", !hit, ak);
    for (int i = 0; i < n; i++) begin
      m.xbyte(8'(d + i), 1'b1, rx, ak);
      chk("data ack", !hit, ak);
    end
    m.stop();
    if (hit && n > 0) begin
      if (c == dwp_pkg::CMD_WR_ZERO) begin
        w0 = d;
        if (n > 1) begin
          w1 = (d + 1) % 256;
        end
      end
      if (c == dwp_pkg::CMD_WR_ONE) begin
        w1 = d;
      end
      if (c == dwp_pkg::CMD_WR_BOTH) begin
        w0 = d;
        w1 = d;
      end
    end
    chk_w();
  endtask
  task automatic rd(input int n);
    logic [7:0] rx;
    logic ak;
    m.start();
    m.xbyte({4'ha, sel, 1'b1}, 1'b1, rx, ak);
    chk("read ack", 1'b0, ak);
    for (int k = 0; k < n; k++) begin
      m.xbyte(8'hff, k == n - 1, rx, ak);
      chk("read data", (k % 2) ? w1[7:0] : w0[7:0], rx);
    end
    m.stop();
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    $display("CHECK FAILED watchdog expected done seen running");
    stop_test();
  end

  initial begin
    logic [7:0] rx;
    logic ak;
    m.tick(4);
    sys_rst <= 1'b0;
    m.tick(4);
    chk_w();
    rd(2);
    for (int i = 0; i < 8; i++) begin
      sel <= i[2:0];
      rnd = lfsr(rnd);
      wr({4'ha, i[2:0], 1'b0}, cmds[i % 3], rnd[7:0], 1 + i % 2);
      rd(3);
    end
    wr({4'hb, sel, 1'b0}, dwp_pkg::CMD_WR_BOTH, 8'h55, 1);
    wr({4'ha, ~sel, 1'b0}, dwp_pkg::CMD_WR_BOTH, 8'h66, 1);
    wr({4'ha, sel, 1'b0}, 8'h00, 8'h77, 1);
    // Abandoned command: a missed restart would load the next address
    m.start();
    m.xbyte({4'ha, sel, 1'b0}, 1'b1, rx, ak);
    m.xbyte(dwp_pkg::CMD_WR_ZERO, 1'b1, rx, ak);
    wr({4'ha, sel, 1'b0}, dwp_pkg::CMD_WR_ONE, 8'h3c, 1);
    wr({4'ha, sel, 1'b0}, dwp_pkg::CMD_WR_ZERO, 8'hf0, 5);
    // Write then read back in one transfer: the queue must drain before the reply
    rnd = lfsr(rnd);
    m.start();
    m.xbyte({4'ha, sel, 1'b0}, 1'b1, rx, ak);
    chk("queue addr ack", 10'h000, ak);
    m.xbyte(dwp_pkg::CMD_WR_BOTH, 1'b1, rx, ak);
    chk("queue cmd ack", 10'h000, ak);
    m.xbyte(rnd[7:0], 1'b1, rx, ak);
    chk("queue data ack", 10'h000, ak);
    w0 = rnd[7:0];
    w1 = rnd[7:0];
    rd(2);
    chk_w();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    m.tick(2);
    sys_rst <= 1'b0;
    w0 = 0;
    w1 = 0;
    m.tick(4);
    chk_w();
    rd(2);
    stop_test();
  end
endmodule

// ==== src/dwp_pkg.sv ====
// Constants and types shared by the dual wiper two-wire slave.
// Assumes a single 10 MHz reference clock samples both bus lines.
//
// Overview of operation
// - Two independent 8-bit wiper registers, each choosing one of 256 taps.
// - Both wipers clear to zero at reset; nothing survives power loss.
// - Three address select pins form the low three slave address bits.
// - Address pins may change anytime; compared live when each address byte ends.
// - Data falling while clock high is a START condition.
// - Data rising while clock high is a STOP condition.
// - Transmitter changes data only while clock low; one clock pulse per bit.
// - Transfers begin only from an idle bus, both lines high.
// - First byte is 4-bit control code, three select bits, direction bit last.
// - Acknowledge the address byte only when code and select bits both match.
// - Acknowledge holds data low through the whole ninth clock high period.
// - Master does not acknowledge the last read byte; device releases data.
// - After a read address the device shifts data out with master clock.
// - Any number of bytes may pass between START and STOP.
// - Repeated START ends a transfer and restarts address decoding.
// - START and STOP delimit transfers in receive and transmit modes.
// - Every byte travels most significant bit first.
// - Works at 100 kHz and 400 kHz serial clock rates.
// - The receiving party generates each acknowledge bit.
// - Reads return wiper zero first, then wiper one.
// - Byte after a write address is a command: write zero, one, or both.
// - Write-zero command loads wiper zero, then optionally wiper one.
// - Write-both command loads the single data byte into both wipers.
package dwp_pkg;

  localparam int WIPER_W = 8;
  localparam logic [7:0] WIPER_RESET = 8'h00;

  // Command byte codes
  localparam logic [7:0] CMD_WR_ZERO = 8'ha9;
  localparam logic [7:0] CMD_WR_ONE = 8'haa;
  localparam logic [7:0] CMD_WR_BOTH = 8'haf;

  // Address byte field positions
  localparam int ADDR_CODE_MSB = 7;
  localparam int ADDR_CODE_LSB = 4;
  localparam int ADDR_SEL_MSB = 3;
  localparam int ADDR_SEL_LSB = 1;
  localparam int ADDR_DIR_BIT = 0;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int FIFO_DEPTH = 32;

  // Serial clock rates the sampler must keep up with
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int FAST_SCL_HZ = 400_000;
  localparam int SAMPLES_PER_SCL = REF_CLK_HZ / FAST_SCL_HZ;

  typedef enum logic [1:0] {
    WR_NONE,
    WR_ZERO,
    WR_ONE,
    WR_BOTH
  } dwp_wr_kind_e;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_CMD,
    PH_DATA
  } dwp_phase_e;

  typedef struct packed {
    dwp_wr_kind_e kind;
    logic [7:0] data;
  } dwp_wr_req_s;

endpackage

// ==== src/dwp_slave.sv ====
// Two-wire slave holding two wiper positions, plus its write request FIFO.
// Assumes an external master drives the clock; both lines arrive
// asynchronously and are sampled by i_ref_clk.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dwp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
module dwp_slave #(
  // Fixed upper address nibble; value is arbitrary
  parameter logic [3:0] CTRL_CODE = 4'ha,
  parameter int FIFO_DEPTH = dwp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // Address straps
  input wire logic [2:0] i_addr_select_pins,
  // Wiper positions
  output logic [dwp_pkg::WIPER_W-1:0] o_wiper_zero_position,
  output logic [dwp_pkg::WIPER_W-1:0] o_wiper_one_position
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } dwp_state_e;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and bus event detection

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [2:0] addr_meta;
  logic [2:0] addr_live;
  logic scl_prev;
  logic sda_prev;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Straps are resampled every cycle through two flops, so a change takes effect two cycles later
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_meta <= 3'h0;
      addr_live <= 3'h0;
    end else begin
      addr_meta <= i_addr_select_pins;
      addr_live <= addr_meta;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s && !scl_prev;
  assign scl_fall = !scl_s && scl_prev;
  // Clock must be high in both samples so a clock edge never fakes a condition
  assign start_det = scl_s && scl_prev && sda_prev && !sda_s;
  assign stop_det = scl_s && scl_prev && !sda_prev && sda_s;

  //////////////////////////////////////////////////////////////////////////////
  // Byte decode helpers

  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] sel);
    addr_match = (b[dwp_pkg::ADDR_CODE_MSB:dwp_pkg::ADDR_CODE_LSB] == CTRL_CODE) &&
                 (b[dwp_pkg::ADDR_SEL_MSB:dwp_pkg::ADDR_SEL_LSB] == sel);
  endfunction

  function automatic dwp_pkg::dwp_wr_kind_e first_kind(input logic [7:0] cmd);
    if (cmd == dwp_pkg::CMD_WR_ZERO) begin
      first_kind = dwp_pkg::WR_ZERO;
    end else if (cmd == dwp_pkg::CMD_WR_ONE) begin
      first_kind = dwp_pkg::WR_ONE;
    end else if (cmd == dwp_pkg::CMD_WR_BOTH) begin
      first_kind = dwp_pkg::WR_BOTH;
    end else begin
      first_kind = dwp_pkg::WR_NONE;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Serial engine

  dwp_state_e state;
  dwp_pkg::dwp_phase_e phase;
  dwp_pkg::dwp_wr_kind_e next_kind;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic rd_dir;
  logic do_ack;
  logic mst_ack;
  logic rd_sel_one;
  logic fifo_in_valid;
  logic fifo_in_ready;
  dwp_pkg::dwp_wr_req_s fifo_in_data;

  // Byte complete: eight rising edges seen and clock now falling
  logic byte_done;
  assign byte_done = (state == ST_RX) && scl_fall && (bit_cnt == dwp_pkg::BITS_PER_BYTE);

  assign fifo_in_data = '{kind: next_kind, data: shreg};
  assign fifo_in_valid = byte_done && (phase == dwp_pkg::PH_DATA) &&
                         (next_kind != dwp_pkg::WR_NONE);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      phase <= dwp_pkg::PH_ADDR;
      next_kind <= dwp_pkg::WR_NONE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      rd_dir <= 1'b0;
      do_ack <= 1'b0;
      mst_ack <= 1'b0;
      rd_sel_one <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (start_det) begin
      // Repeated or first START: always restart address decoding
      state <= ST_RX;
      phase <= dwp_pkg::PH_ADDR;
      bit_cnt <= 4'h0;
      o_sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state <= ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          o_sda_oe_n <= 1'b1;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt != dwp_pkg::BITS_PER_BYTE) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            state <= ST_ACK;
            case (phase)
              dwp_pkg::PH_ADDR: begin
                if (addr_match(shreg, addr_live)) begin
                  rd_dir <= shreg[dwp_pkg::ADDR_DIR_BIT];
                  do_ack <= 1'b1;
                  o_sda_oe_n <= 1'b0;
                end else begin
                  state <= ST_IDLE;
                end
              end
              dwp_pkg::PH_CMD: begin
                next_kind <= first_kind(shreg);
                phase <= dwp_pkg::PH_DATA;
                do_ack <= 1'b1;
                o_sda_oe_n <= 1'b0;
              end
              default: begin
                // Extra bytes are acknowledged and dropped
                if (next_kind == dwp_pkg::WR_ZERO) begin
                  next_kind <= dwp_pkg::WR_ONE;
                end else begin
                  next_kind <= dwp_pkg::WR_NONE;
                end
                // A full queue refuses the byte with a not-acknowledge
                do_ack <= fifo_in_ready || !fifo_in_valid;
                o_sda_oe_n <= !(fifo_in_ready || !fifo_in_valid);
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (phase == dwp_pkg::PH_ADDR && rd_dir && do_ack) begin
              // First read byte goes out on the same falling edge
              state <= ST_TX;
              shreg <= o_wiper_zero_position;
              rd_sel_one <= 1'b1;
              o_sda_oe_n <= o_wiper_zero_position[7];
            end else begin
              if (phase == dwp_pkg::PH_ADDR) begin
                phase <= dwp_pkg::PH_CMD;
              end
              state <= ST_RX;
              o_sda_oe_n <= 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              state <= ST_MACK;
              o_sda_oe_n <= 1'b1;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
              o_sda_oe_n <= shreg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mst_ack <= !sda_s;
          end else if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (mst_ack) begin
              state <= ST_TX;
              shreg <= rd_sel_one ? o_wiper_one_position : o_wiper_zero_position;
              o_sda_oe_n <= rd_sel_one ? o_wiper_one_position[7] : o_wiper_zero_position[7];
              rd_sel_one <= !rd_sel_one;
            end else begin
              state <= ST_IDLE;
              o_sda_oe_n <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pull-down only: the data value is a constant low
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sda <= 1'b0;
    end else begin
      o_sda <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write queue and wiper update

  logic fifo_out_valid;
  logic fifo_out_ready;
  dwp_pkg::dwp_wr_req_s fifo_out_data;

  // Hold updates while a byte is shifting out so a read never sees a torn
  // value; the queue drains in a few cycles, far faster than any bus byte.
  assign fifo_out_ready = (state != ST_TX);

  dwp_fifo #(
    .WIDTH($bits(dwp_pkg::dwp_wr_req_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wiper_zero_position <= dwp_pkg::WIPER_RESET;
      o_wiper_one_position <= dwp_pkg::WIPER_RESET;
    end else if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out_data.kind == dwp_pkg::WR_ZERO ||
          fifo_out_data.kind == dwp_pkg::WR_BOTH) begin
        o_wiper_zero_position <= fifo_out_data.data;
      end
      if (fifo_out_data.kind == dwp_pkg::WR_ONE ||
          fifo_out_data.kind == dwp_pkg::WR_BOTH) begin
        o_wiper_one_position <= fifo_out_data.data;
      end
    end
  end

endmodule
